// *** src/sarc_top.sv ***
// sweep accumulator restart control with apb register access
`timescale 1ns/100ps
module sarc_top #(
    parameter int NCH      = 2,
    parameter int CH_W     = 1,
    parameter int SAMPLE_W = 12,
    parameter int ACC_W    = 24,
    parameter int CNT_W    = 16
) (
    input  logic                          pclk,
    input  logic                          presetn,
    input  logic [sarc_pkg::ADDR_W-1:0]   paddr,
    input  logic                          psel,
    input  logic                          penable,
    input  logic                          pwrite,
    input  logic [31:0]                   pwdata,
    output logic                          pready,
    output logic [31:0]                   prdata,
    output logic                          pslverr,
    input  logic                          start_press,
    input  logic                          sync_pulse,
    input  logic                          sweep_end,
    input  logic                          sample_valid,
    input  logic [CH_W-1:0]               sample_ch,
    input  logic signed [SAMPLE_W-1:0]    sample_data,
    input  logic signed [ACC_W-1:0]       mem_rdata,
    output logic signed [ACC_W-1:0]       mem_wdata,
    output logic                          mem_we,
    input  logic [NCH-1:0]                panel_polarity_inv,
    input  logic [NCH-1:0]                external_polarity_source,
    output logic                          run_complete_lamp,
    output logic [sarc_pkg::FIELD_W-1:0]  display_shift,
    output logic [2*ACC_W+1:0]            variance_data,
    output logic                          variance_valid
);
    localparam int FW = sarc_pkg::FIELD_W;

    sarc_pkg::sarc_state_t state_q;
    sarc_pkg::sarc_state_t state_d;
    logic [11:0]                  ctrl_q;
    logic [11:0]                  ctrl_d;
    logic [CNT_W-1:0]             sweep_cnt_q;
    logic [CNT_W-1:0]             sweep_cnt_d;
    logic [CNT_W-1:0]             run_cnt_q;
    logic [CNT_W-1:0]             run_cnt_d;
    logic                         first_q;
    logic                         first_d;
    logic signed [ACC_W-1:0]      wdata_q;
    logic signed [ACC_W-1:0]      wdata_d;
    logic                         we_q;
    logic                         we_d;
    logic [FW-1:0]                shift_q;
    logic [FW-1:0]                shift_d;
    logic [31:0]                  rdata_q;
    logic [31:0]                  rdata_d;
    logic                         err_q;
    logic                         err_d;
    logic                         apb_acc;
    logic                         apb_wr;
    logic                         start_evt;
    logic                         sum_mode;
    logic                         auto_scale;
    logic                         special;
    logic                         ext_sel;
    logic [FW-1:0]                gain_power_select;
    logic [FW-1:0]                sweep_power;
    logic [CNT_W-1:0]             target;
    logic [CNT_W-1:0]             run_next;
    logic                         run_end;
    logic [NCH-1:0]               ch_invert;
    logic signed [SAMPLE_W:0]     ch_sample [NCH];
    logic signed [ACC_W-1:0]      x_ext;
    logic signed [ACC_W-1:0]      avg_step;
    logic [FW-1:0]                avg_k;

    function automatic logic [FW-1:0] flog2(input logic [CNT_W-1:0] v);
        logic [FW-1:0] r;
        r = '0;
        for (int i = 0; i < CNT_W; i++)
            if (v[i])
                r = FW'(i);
        return r;
    endfunction : flog2

    // one polarity selector per input channel
    for (genvar c = 0; c < NCH; c++)
    begin : g_pol
        sarc_polarity #(
            .SAMPLE_W    (SAMPLE_W)
        ) u_pol (
            .ext_select  (ext_sel),
            .panel_invert(panel_polarity_inv[c]),
            .ext_level   (external_polarity_source[c]),
            .sample_in   (sample_data),
            .invert      (ch_invert[c]),
            .sample_out  (ch_sample[c])
        );
    end

    sarc_variance #(
        .ACC_W         (ACC_W)
    ) u_var (
        .pclk          (pclk),
        .presetn       (presetn),
        .point_valid   (sample_valid),
        .sample        (x_ext),
        .average       (mem_rdata),
        .variance_data (variance_data),
        .variance_valid(variance_valid)
    );

    assign apb_acc           = psel & penable;
    assign apb_wr            = apb_acc & pwrite;
    assign pready            = 1'b1;
    assign sum_mode          = ctrl_q[sarc_pkg::CTRL_SUM_BIT];
    assign auto_scale        = ctrl_q[sarc_pkg::CTRL_AUTO_BIT];
    assign special           = ctrl_q[sarc_pkg::CTRL_SPECIAL_BIT];
    assign ext_sel           = ctrl_q[sarc_pkg::CTRL_EXTPOL_BIT];
    assign gain_power_select = ctrl_q[sarc_pkg::CTRL_GAIN_LSB +: FW];
    assign sweep_power       = ctrl_q[sarc_pkg::CTRL_SWEEP_LSB +: FW];
    assign start_evt         = start_press |
                               (apb_wr && paddr == sarc_pkg::CMD_OFS && pwdata[sarc_pkg::CMD_START_BIT]);
    assign target            = CNT_W'(1) << sweep_power;
    assign run_next          = run_cnt_q + CNT_W'(1);
    assign run_end           = state_q == sarc_pkg::ST_SWEEP && sweep_end;
    assign x_ext             = ACC_W'(ch_sample[sample_ch]);
    assign avg_k             = flog2(run_next);
    assign avg_step          = (x_ext - mem_rdata) >>> avg_k;

    // register file and apb answer
    always_comb
    begin
        ctrl_d  = ctrl_q;
        rdata_d = sarc_pkg::RDATA_ZERO;
        err_d   = 1'b0;
        if (apb_wr && paddr == sarc_pkg::CTRL_OFS)
            ctrl_d = pwdata[11:0];
        if (psel && !penable)
        begin
            if (paddr == sarc_pkg::CTRL_OFS)
                rdata_d = {20'h00000, ctrl_q};
            else if (paddr == sarc_pkg::CMD_OFS)
                rdata_d = sarc_pkg::RDATA_ZERO;
            else if (paddr == sarc_pkg::STAT_OFS)
            begin
                rdata_d[sarc_pkg::STAT_DONE_BIT]           = run_complete_lamp;
                rdata_d[sarc_pkg::STAT_RUN_BIT]            = state_q != sarc_pkg::ST_IDLE &&
                                                             state_q != sarc_pkg::ST_DONE;
                rdata_d[sarc_pkg::STAT_SHIFT_LSB +: FW]    = shift_q;
            end
            else if (paddr == sarc_pkg::COUNT_OFS)
                rdata_d = 32'(sweep_cnt_q);
            else
                err_d = 1'b1;
        end
    end

    // sweep run control
    always_comb
    begin
        state_d     = state_q;
        sweep_cnt_d = sweep_cnt_q;
        run_cnt_d   = run_cnt_q;
        first_d     = first_q;
        case (state_q)
            sarc_pkg::ST_IDLE:
                if (start_evt)
                    state_d = sarc_pkg::ST_ARMED;
            sarc_pkg::ST_ARMED:
                if (sync_pulse)
                    state_d = sarc_pkg::ST_SWEEP;
            sarc_pkg::ST_SWEEP:
                if (sweep_end)
                begin
                    sweep_cnt_d = sweep_cnt_q + CNT_W'(1);
                    run_cnt_d   = run_next;
                    first_d     = 1'b0;
                    if (run_next == target)
                    begin
                        state_d = sarc_pkg::ST_DONE;
                        if (special)
                            sweep_cnt_d = '0;
                    end
                    else
                        state_d = sarc_pkg::ST_ARMED;
                end
            sarc_pkg::ST_DONE:
                if (start_evt)
                begin
                    state_d   = sarc_pkg::ST_ARMED;
                    run_cnt_d = '0;
                end
            default:
                state_d = sarc_pkg::ST_IDLE;
        endcase
        if (start_evt && !sum_mode)
        begin
            state_d   = sarc_pkg::ST_ARMED;
            run_cnt_d = '0;
            first_d   = 1'b1;
        end
        if (start_evt && sum_mode && state_q == sarc_pkg::ST_IDLE)
            run_cnt_d = '0;
    end

    // accumulation and display scaling
    always_comb
    begin
        wdata_d = wdata_q;
        we_d    = 1'b0;
        if (state_q == sarc_pkg::ST_SWEEP && sample_valid)
        begin
            we_d = 1'b1;
            if (sum_mode)
                wdata_d = mem_rdata + x_ext;
            else if (first_q)
                wdata_d = x_ext;
            else
                wdata_d = mem_rdata + avg_step;
        end
        if (!sum_mode)
            shift_d = '0;
        else if (!auto_scale)
            shift_d = gain_power_select;
        else if (state_d == sarc_pkg::ST_DONE)
            shift_d = '0;
        else
            shift_d = flog2(run_cnt_d);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q     <= sarc_pkg::ST_IDLE;
            ctrl_q      <= sarc_pkg::CTRL_RESET;
            sweep_cnt_q <= '0;
            run_cnt_q   <= '0;
            first_q     <= 1'b1;
            wdata_q     <= '0;
            we_q        <= 1'b0;
            shift_q     <= '0;
            rdata_q     <= sarc_pkg::RDATA_ZERO;
            err_q       <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            ctrl_q      <= ctrl_d;
            sweep_cnt_q <= sweep_cnt_d;
            run_cnt_q   <= run_cnt_d;
            first_q     <= first_d;
            wdata_q     <= wdata_d;
            we_q        <= we_d;
            shift_q     <= shift_d;
            rdata_q     <= rdata_d;
            err_q       <= err_d;
        end
    end

    assign run_complete_lamp = state_q == sarc_pkg::ST_DONE;
    assign mem_wdata         = wdata_q;
    assign mem_we            = we_q;
    assign display_shift     = shift_q;
    assign prdata            = rdata_q;
    assign pslverr           = err_q & apb_acc;

    erase_on_done_a: assert property (@(posedge pclk) disable iff (!presetn)
        run_end && run_next == target && special && !start_evt |=> run_complete_lamp && sweep_cnt_q == 0)
        else $error("sweep count not erased at run end");

    keep_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        run_end && !special && !start_evt |=> sweep_cnt_q == CNT_W'($past(sweep_cnt_q) + 1))
        else $error("sweep count not kept in normal mode");

    done_scale_a: assert property (@(posedge pclk) disable iff (!presetn)
        run_complete_lamp && sum_mode && auto_scale && !start_evt |=> display_shift == 0)
        else $error("finished summation not scaled as one sweep");

    start_rescale_a: assert property (@(posedge pclk) disable iff (!presetn)
        run_complete_lamp && start_evt && sum_mode |=> run_cnt_q == 0 && !mem_we ##1 !mem_we)
        else $error("start did not restart display scaling");

    manual_scale_a: assert property (@(posedge pclk) disable iff (!presetn)
        sum_mode && !auto_scale && $stable(ctrl_q) |=> display_shift == $past(gain_power_select))
        else $error("manual scale not taken from gain setting");

    avg_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
        start_evt && !sum_mode |=> state_q == sarc_pkg::ST_ARMED && run_cnt_q == 0 && first_q)
        else $error("average not restarted on start");

    first_overwrite_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == sarc_pkg::ST_SWEEP && sample_valid && !sum_mode && first_q
        |=> mem_we && mem_wdata == $past(x_ext))
        else $error("first average sweep did not overwrite");

    sum_add_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == sarc_pkg::ST_SWEEP && sample_valid && sum_mode
        |=> mem_we && mem_wdata == ACC_W'($past(mem_rdata) + $past(x_ext)))
        else $error("summation did not add onto memory");

    ext_polarity_a: assert property (@(posedge pclk) disable iff (!presetn)
        ext_sel && !external_polarity_source[sample_ch] |-> x_ext == -ACC_W'(sample_data))
        else $error("external low did not invert");

    run_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        run_complete_lamp && !start_evt |=> run_complete_lamp && !mem_we)
        else $error("accumulation did not stop at run end");
endmodule : sarc_top

// *** src/sarc_pkg.sv ***
// constants and types shared by the sweep accumulator restart control
package sarc_pkg;
    localparam int          ADDR_W           = 8;
    localparam int          FIELD_W          = 4;
    localparam logic [7:0]  CTRL_OFS         = 8'h00;
    localparam logic [7:0]  CMD_OFS          = 8'h04;
    localparam logic [7:0]  STAT_OFS         = 8'h08;
    localparam logic [7:0]  COUNT_OFS        = 8'h0c;
    localparam int          CTRL_SUM_BIT     = 0;
    localparam int          CTRL_AUTO_BIT    = 1;
    localparam int          CTRL_SPECIAL_BIT = 2;
    localparam int          CTRL_EXTPOL_BIT  = 3;
    localparam int          CTRL_GAIN_LSB    = 4;
    localparam int          CTRL_SWEEP_LSB   = 8;
    localparam int          CMD_START_BIT    = 0;
    localparam int          STAT_DONE_BIT    = 0;
    localparam int          STAT_RUN_BIT     = 1;
    localparam int          STAT_SHIFT_LSB   = 4;
    localparam logic [11:0] CTRL_RESET       = 12'h000;
    localparam logic [31:0] RDATA_ZERO       = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_SWEEP = 2'b10,
        ST_DONE  = 2'b11
    } sarc_state_t;
endpackage : sarc_pkg

// *** src/sarc_polarity.sv ***
// polarity source selection and sample inversion for one input channel
`timescale 1ns/100ps
module sarc_polarity #(
    parameter int SAMPLE_W = 12
) (
    input  logic                       ext_select,
    input  logic                       panel_invert,
    input  logic                       ext_level,
    input  logic signed [SAMPLE_W-1:0] sample_in,
    output logic                       invert,
    output logic signed [SAMPLE_W:0]   sample_out
);
    // external: open or high is normal, closure or low inverts
    assign invert     = ext_select ? ~ext_level : panel_invert;
    assign sample_out = invert ? -(SAMPLE_W+1)'(sample_in) : (SAMPLE_W+1)'(sample_in);
endmodule : sarc_polarity

// *** src/sarc_variance.sv ***
// squared difference of input and stored average, one point late
`timescale 1ns/100ps
module sarc_variance #(
    parameter int ACC_W = 24
) (
    input  logic                   pclk,
    input  logic                   presetn,
    input  logic                   point_valid,
    input  logic signed [ACC_W-1:0] sample,
    input  logic signed [ACC_W-1:0] average,
    output logic [2*ACC_W+1:0]     variance_data,
    output logic                   variance_valid
);
    logic signed [ACC_W:0]     diff;
    logic [2*ACC_W+1:0]        square;
    logic [2*ACC_W+1:0]        held_q;
    logic [2*ACC_W+1:0]        held_d;
    logic [2*ACC_W+1:0]        out_q;
    logic [2*ACC_W+1:0]        out_d;
    logic                      have_q;
    logic                      have_d;
    logic                      vld_q;
    logic                      vld_d;

    always_comb
    begin
        diff   = (ACC_W+1)'(sample) - (ACC_W+1)'(average);
        square = (2*ACC_W+2)'(diff * diff);
        held_d = held_q;
        out_d  = out_q;
        have_d = have_q;
        vld_d  = 1'b0;
        if (point_valid)
        begin
            held_d = square;
            have_d = 1'b1;
            out_d  = held_q;
            vld_d  = have_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            held_q <= '0;
            out_q  <= '0;
            have_q <= 1'b0;
            vld_q  <= 1'b0;
        end
        else
        begin
            held_q <= held_d;
            out_q  <= out_d;
            have_q <= have_d;
            vld_q  <= vld_d;
        end
    end

    assign variance_data  = out_q;
    assign variance_valid = vld_q;

    var_offset_a: assert property (@(posedge pclk) disable iff (!presetn)
        point_valid && have_q |=> variance_valid && variance_data == $past(held_q))
        else $error("variance sample not one point late");

    var_square_a: assert property (@(posedge pclk) disable iff (!presetn)
        point_valid |=> held_q == $past(square) && have_q)
        else $error("variance square not captured");
endmodule : sarc_variance

// *** bench/sarc_panel_model.sv ***
// front-panel operator and external polarity contact model
`timescale 1ns/100ps
module sarc_panel_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       press,
    input  wire logic [1:0] contact,
    output logic            start_press,
    output logic [1:0]      external_polarity_source
);
    logic press_q;
    // a held button gives one start pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            press_q     <= 1'b0;
            start_press <= 1'b0;
        end
        else
        begin
            press_q     <= press;
            start_press <= press & ~press_q;
        end
    end
    // open contact reads high, closure reads low
    assign external_polarity_source = ~contact;
endmodule : sarc_panel_model

// *** bench/tb.sv ***
// self-checking testbench for the sweep accumulator restart control
`timescale 1ns/100ps
module tb;
    typedef struct packed {
        logic               ext;
        logic               ch;
        logic [1:0]         inv;
        logic [1:0]         cls;
        logic signed [11:0] s;
        logic signed [23:0] r;
        logic signed [23:0] w;
    } sarc_row_t;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic               err, press, start_press, sync_pulse, sweep_end, sample_valid, sample_ch;
    logic [1:0]         contact, panel_inv, ext_src;
    logic signed [11:0] sample_data;
    logic signed [23:0] mem_rdata, mem_wdata;
    logic               mem_we, lamp, variance_valid;
    logic [3:0]         display_shift;
    logic [49:0]        variance_data;
    int                 n_fail, checks_done;
    sarc_row_t          rows [6];

    sarc_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .start_press(start_press), .sync_pulse(sync_pulse), .sweep_end(sweep_end),
        .sample_valid(sample_valid), .sample_ch(sample_ch), .sample_data(sample_data),
        .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_we(mem_we), .panel_polarity_inv(panel_inv),
        .external_polarity_source(ext_src), .run_complete_lamp(lamp), .display_shift(display_shift),
        .variance_data(variance_data), .variance_valid(variance_valid));
    sarc_panel_model panel (.pclk(pclk), .presetn(presetn), .press(press), .contact(contact),
        .start_press(start_press), .external_polarity_source(ext_src));

    task test_done;
        if (n_fail == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    task chk(input string name, input logic [49:0] exp, input logic [49:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask : chk

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task tick(input logic st, input logic sy, input logic se);
        @(posedge pclk);
        press      <= st;
        sync_pulse <= sy;
        sweep_end  <= se;
        @(posedge pclk);
        press      <= 1'b0;
        sync_pulse <= 1'b0;
        sweep_end  <= 1'b0;
    endtask : tick

    task samp(input logic c, input logic signed [11:0] s, input logic signed [23:0] r);
        @(posedge pclk);
        sample_valid <= 1'b1;
        sample_ch    <= c;
        sample_data  <= s;
        mem_rdata    <= r;
        @(posedge pclk);
        sample_valid <= 1'b0;
        #1;
    endtask : samp

    task sweep(input logic signed [11:0] s, input logic signed [23:0] r, input logic signed [23:0] w);
        tick(1'b0, 1'b1, 1'b0);
        samp(1'b0, s, r);
        chk("mem_wdata", w, mem_wdata);
        tick(1'b0, 1'b0, 1'b1);
        repeat (2) @(posedge pclk);
    endtask : sweep

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    initial
    begin
        #100us;
        n_fail++;
        test_done();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, press, sync_pulse, sweep_end, sample_valid, sample_ch} = '0;
        {paddr, pwdata, contact, panel_inv, sample_data, mem_rdata} = '0;
        rows = '{'{1'b0, 1'b0, 2'h0, 2'h0, 12'h064, 24'h0003e8, 24'h00044c},
                 '{1'b0, 1'b0, 2'h1, 2'h0, 12'h064, 24'h0003e8, 24'h000384},
                 '{1'b0, 1'b1, 2'h1, 2'h0, 12'h064, 24'h0003e8, 24'h00044c},
                 '{1'b1, 1'b0, 2'h3, 2'h0, 12'h064, 24'h0003e8, 24'h00044c},
                 '{1'b1, 1'b1, 2'h0, 2'h2, 12'h064, 24'h0003e8, 24'h000384},
                 '{1'b1, 1'b0, 2'h0, 2'h1, 12'hfce, 24'h000000, 24'h000032}};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        chk("lamp", 50'h0, lamp);
        chk("pready", 50'h1, pready);
        apb(1'b0, sarc_pkg::CTRL_OFS, 32'h0);
        chk("ctrl", 50'h0, rd);
        apb(1'b0, 8'h10, 32'h0);
        chk("pslverr", 50'h1, err);
        // polarity table, one-sweep summation runs
        foreach (rows[i])
        begin
            apb(1'b1, sarc_pkg::CTRL_OFS, 32'h1 | (32'(rows[i].ext) << 3));
            @(posedge pclk);
            panel_inv <= rows[i].inv;
            contact   <= rows[i].cls;
            tick(1'b1, 1'b0, 1'b0);
            tick(1'b0, 1'b1, 1'b0);
            samp(rows[i].ch, rows[i].s, rows[i].r);
            chk("mem_we", 50'h1, mem_we);
            chk("mem_wdata", rows[i].w, mem_wdata);
            tick(1'b0, 1'b0, 1'b1);
            repeat (2) @(posedge pclk);
            chk("lamp", 50'h1, lamp);
        end
        samp(1'b0, 12'h001, 24'h000001);
        chk("mem_we", 50'h0, mem_we);
        // reset after the finished run, then two-sweep auto-scaled summation
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        contact <= 2'h0;
        apb(1'b1, sarc_pkg::CTRL_OFS, 32'h103);
        tick(1'b1, 1'b0, 1'b0);
        sweep(12'h010, 24'h000020, 24'h000030);
        chk("lamp", 50'h0, lamp);
        sweep(12'h010, 24'h000030, 24'h000040);
        chk("lamp", 50'h1, lamp);
        chk("display_shift", 50'h0, display_shift);
        apb(1'b0, sarc_pkg::COUNT_OFS, 32'h0);
        chk("count", 50'h2, rd);
        apb(1'b0, sarc_pkg::STAT_OFS, 32'h0);
        chk("status_lamp", 50'h1, rd[sarc_pkg::STAT_DONE_BIT]);
        apb(1'b1, sarc_pkg::CTRL_OFS, 32'h107);
        apb(1'b1, sarc_pkg::CMD_OFS, 32'h1);
        repeat (2) @(posedge pclk);
        chk("lamp", 50'h0, lamp);
        chk("display_shift", 50'h0, display_shift);
        sweep(12'h010, 24'h000040, 24'h000050);
        sweep(12'h010, 24'h000050, 24'h000060);
        chk("lamp", 50'h1, lamp);
        apb(1'b0, sarc_pkg::COUNT_OFS, 32'h0);
        chk("count", 50'h0, rd);
        apb(1'b1, sarc_pkg::CTRL_OFS, 32'h151);
        repeat (2) @(posedge pclk);
        chk("display_shift", 50'h5, display_shift);
        // average mode: overwrite, variance, restart
        apb(1'b1, sarc_pkg::CTRL_OFS, 32'h100);
        tick(1'b1, 1'b0, 1'b0);
        tick(1'b0, 1'b1, 1'b0);
        samp(1'b0, 12'h005, 24'h000002);
        chk("mem_wdata", 50'h5, mem_wdata);
        samp(1'b0, 12'h007, 24'h000003);
        chk("mem_wdata", 50'h7, mem_wdata);
        chk("variance_valid", 50'h1, variance_valid);
        chk("variance_data", 50'h9, variance_data);
        tick(1'b0, 1'b0, 1'b1);
        tick(1'b0, 1'b1, 1'b0);
        samp(1'b0, 12'h00a, 24'h000002);
        chk("mem_wdata", 50'h6, mem_wdata);
        tick(1'b1, 1'b0, 1'b0);
        tick(1'b0, 1'b1, 1'b0);
        samp(1'b0, 12'h00a, 24'h000002);
        chk("mem_wdata", 50'ha, mem_wdata);
        chk("display_shift", 50'h0, display_shift);
        test_done();
    end
endmodule : tb
